// file: rtl/tmo_pkg.sv
// Shared constants for the timer one clock and control block
package tmo_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_CNT_LO    = 8'h04;
  localparam logic [7:0]  OFF_CNT_HI    = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h0c;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  OFF_IRQ_CFG   = 8'h14;
  // Control register field positions
  localparam int          CS_HI         = 7;
  localparam int          CS_LO         = 6;
  localparam int          PS_HI         = 5;
  localparam int          PS_LO         = 4;
  localparam int          OSC_EN_BIT    = 3;
  localparam int          SYNC_DIS_BIT  = 2;
  localparam int          RUN_BIT       = 0;
  localparam logic [7:0]  CTRL_IMPL     = 8'hfd;
  // Values after reset
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
  localparam logic [2:0]  PRE_RST       = 3'h0;
  localparam logic [2:0]  SYN_RST       = 3'h0;
  // Count clock source codes
  localparam logic [1:0]  SRC_INSN      = 2'h0;
  localparam logic [1:0]  SRC_SYS       = 2'h1;
  localparam logic [1:0]  SRC_PIN       = 2'h2;
  localparam logic [1:0]  SRC_CAP       = 2'h3;
  // Instruction clock is every fourth system clock
  localparam logic [1:0]  INSN_DIV_LAST = 2'h3;
  // External source lanes in the synchroniser
  localparam int          XS_CAP        = 0;
  localparam int          XS_PIN        = 1;
  localparam int          XS_XTAL       = 2;
  localparam int          XS_N          = 3;
  // Interrupt event bits and peripheral enable bit
  localparam int          EV_OVF        = 0;
  localparam int          EV_STOP       = 1;
  localparam int          PIE_BIT       = 0;
endpackage

// file: rtl/tmo_tick_if.sv
// Tick signals passed between the timer core, synchroniser, prescaler
`timescale 1ns/100ps
interface tmo_tick_if;
  logic [2:0] src_edge;
  logic       bypass;
  logic       cnt_tick;
  logic [1:0] pre_sel;
  logic       pre_clr;
  logic       pre_tick;
  modport sync  (input bypass, output src_edge);
  modport presc (input cnt_tick, input pre_sel, input pre_clr,
                 output pre_tick);
  modport core  (input src_edge, input pre_tick, output bypass,
                 output cnt_tick, output pre_sel, output pre_clr);
endinterface

// file: rtl/tmo_edge_sync.sv
// Two-stage synchroniser and rising edge detect for external sources
`timescale 1ns/100ps
module tmo_edge_sync
  import tmo_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            sys_rst,
  input  wire logic [XS_N-1:0] raw_in,
  tmo_tick_if.sync             tk
);
  typedef struct packed {
    logic [XS_N-1:0] s1;
    logic [XS_N-1:0] s2;
    logic [XS_N-1:0] s3;
    logic [XS_N-1:0] s4;
  } tmo_sync_s;

  tmo_sync_s r_reg;
  tmo_sync_s r_next;

  // Shift chain; first stage only feeds the second
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = raw_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.s4 = r_reg.s3;
    if (sys_rst) begin
      r_next = '{SYN_RST, SYN_RST, SYN_RST, SYN_RST};
    end
  end

  always_ff @(posedge core_clk) begin
    r_reg <= r_next;
  end

  // Per-lane edge; aligned stage unless bypassed
  genvar i;
  generate
    for (i = 0; i < XS_N; i++) begin : g_lane
      assign tk.src_edge[i] = tk.bypass ? (r_reg.s2[i] & ~r_reg.s3[i])
                                        : (r_reg.s3[i] & ~r_reg.s4[i]);
    end
  endgenerate
endmodule // tmo_edge_sync

// file: rtl/tmo_prescaler.sv
// Count clock prescaler dividing ticks by 1, 2, 4 or 8
`timescale 1ns/100ps
module tmo_prescaler
  import tmo_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  tmo_tick_if.presc tk
);
  typedef struct packed {
    logic [2:0] cnt;
  } tmo_pre_s;

  tmo_pre_s   r_reg;
  tmo_pre_s   r_next;
  logic [2:0] last;

  assign last        = 3'((4'h1 << tk.pre_sel) - 4'h1);
  assign tk.pre_tick = tk.cnt_tick & (r_reg.cnt == last);

  // Tick counter, restarts when cleared
  always_comb begin
    r_next = r_reg;
    if (tk.cnt_tick) begin
      r_next.cnt = tk.pre_tick ? PRE_RST : 3'(r_reg.cnt + 3'h1);
    end
    if (sys_rst || tk.pre_clr) begin
      r_next.cnt = PRE_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    r_reg <= r_next;
  end

  div_eight_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tk.pre_sel == 2'h3 && tk.pre_tick && !tk.pre_clr)
      |=> !tk.pre_tick [*7])
    else $error("divide by eight ticked too soon");
endmodule // tmo_prescaler

// file: rtl/tmo_timer_core.sv
// Timer one count clock selection, control and APB register file
//
// Summary of operation
// - Selector 11 counts capacitive oscillator edges
// - Selector 10, crystal off: count pin rises
// - Selector 10, crystal on: count crystal
// - Selector 01 counts every system clock
// - Selector 00 counts system clock over four
// - Prescale divides by 1, 2, 4, 8
// - Crystal enable bit powers crystal oscillator
// - External source synchronised unless disable bit set
// - Internal sources ignore the synchronise-disable bit
// - Run bit counts; stop clears gate flip-flop
// - Control clears on power reset only
// - Count read/written as two bytes
// - Overflow interrupt needs its enable bit
// - Peripheral enable gates every interrupt
`timescale 1ns/100ps
module tmo_timer_core
  import tmo_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        other_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cap_sense_oscillator,
  input  wire logic        ext_count_input,
  input  wire logic        crystal_osc_pins,
  output logic             crystal_osc_enable,
  output logic             gate_ff_clear,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cnt;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic        pie;
    logic [1:0]  div4;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
    logic        osc_en;
    logic        gate_clr;
  } tmo_state_s;

  tmo_state_s  r_reg;
  tmo_state_s  r_next;
  tmo_tick_if  tk ();

  logic        setup;
  logic        wr;
  logic        run;
  logic [1:0]  cs;
  logic        osc;
  logic        wr_ctrl;
  logic        wr_lo;
  logic        wr_hi;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_cfg;
  logic        mapped;
  logic        inc;
  logic        wrap;
  logic        stop_ev;
  logic [1:0]  ev;
  logic [31:0] rd_mux;

  // External edges and prescaler
  tmo_edge_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .raw_in   ({crystal_osc_pins, ext_count_input, cap_sense_oscillator}),
    .tk       (tk.sync)
  );

  tmo_prescaler u_presc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tk       (tk.presc)
  );

  // Bus phase decode
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & r_reg.ready & pwrite;
  assign wr_ctrl = wr & (paddr == OFF_CTRL);
  assign wr_lo   = wr & (paddr == OFF_CNT_LO);
  assign wr_hi   = wr & (paddr == OFF_CNT_HI);
  assign wr_stat = wr & (paddr == OFF_IRQ_STAT);
  assign wr_mask = wr & (paddr == OFF_IRQ_MASK);
  assign wr_cfg  = wr & (paddr == OFF_IRQ_CFG);

  assign run = r_reg.ctrl[RUN_BIT];
  assign cs  = r_reg.ctrl[CS_HI:CS_LO];
  assign osc = r_reg.ctrl[OSC_EN_BIT];

  assign tk.bypass = cs[1] & r_reg.ctrl[SYNC_DIS_BIT];

  // Count clock source selection
  always_comb begin
    tk.cnt_tick = 1'b0;
    unique case (cs)
      SRC_INSN: tk.cnt_tick = (r_reg.div4 == INSN_DIV_LAST);
      SRC_SYS:  tk.cnt_tick = 1'b1;
      SRC_PIN:  tk.cnt_tick = osc ? tk.src_edge[XS_XTAL]
                                  : tk.src_edge[XS_PIN];
      SRC_CAP:  tk.cnt_tick = tk.src_edge[XS_CAP];
    endcase
  end

  assign tk.pre_sel = r_reg.ctrl[PS_HI:PS_LO];
  assign tk.pre_clr = ~run | wr_lo | wr_hi;

  assign inc     = run & tk.pre_tick;
  assign wrap    = inc & (r_reg.cnt == 16'hffff);
  assign stop_ev = wr_ctrl & run & ~pwdata[RUN_BIT];
  assign ev      = {stop_ev, wrap};

  // Read data for the addressed register
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      OFF_CTRL:     rd_mux[7:0] = r_reg.ctrl & CTRL_IMPL;
      OFF_CNT_LO:   rd_mux[7:0] = r_reg.cnt[7:0];
      OFF_CNT_HI:   rd_mux[7:0] = r_reg.cnt[15:8];
      OFF_IRQ_STAT: rd_mux[1:0] = r_reg.stat;
      OFF_IRQ_MASK: rd_mux[1:0] = r_reg.mask;
      OFF_IRQ_CFG:  rd_mux[PIE_BIT] = r_reg.pie;
      default:      mapped = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    r_next      = r_reg;
    r_next.div4 = 2'(r_reg.div4 + 2'h1);
    if (inc) begin
      r_next.cnt = 16'(r_reg.cnt + 16'h0001);
    end
    if (wr_lo) begin
      r_next.cnt[7:0] = pwdata[7:0];
    end
    if (wr_hi) begin
      r_next.cnt[15:8] = pwdata[7:0];
    end
    if (wr_ctrl) begin
      r_next.ctrl = pwdata[7:0] & CTRL_IMPL;
    end
    if (wr_mask) begin
      r_next.mask = pwdata[1:0];
    end
    if (wr_cfg) begin
      r_next.pie = pwdata[PIE_BIT];
    end
    // Sticky events, set beats clear
    r_next.stat = r_reg.stat;
    if (wr_stat) begin
      r_next.stat = r_reg.stat & ~pwdata[1:0];
    end
    r_next.stat   = r_next.stat | ev;
    // Registered zero-wait answer
    r_next.ready  = setup;
    r_next.slverr = setup & ~mapped;
    r_next.rdata  = setup ? rd_mux : 32'h0000_0000;
    // Control reset variants
    if (other_rst) begin
      r_next.stat  = IRQ_RST;
      r_next.mask  = IRQ_RST;
      r_next.pie   = 1'b0;
      r_next.div4  = 2'h0;
      r_next.ready = 1'b0;
      r_next.slverr = 1'b0;
      r_next.rdata = 32'h0000_0000;
    end
    if (sys_rst) begin
      r_next.ctrl  = CTRL_RST;
      r_next.cnt   = CNT_RST;
      r_next.stat  = IRQ_RST;
      r_next.mask  = IRQ_RST;
      r_next.pie   = 1'b0;
      r_next.div4  = 2'h0;
      r_next.ready = 1'b0;
      r_next.slverr = 1'b0;
      r_next.rdata = 32'h0000_0000;
    end
    r_next.irq      = (|(r_next.stat & r_next.mask)) & r_next.pie;
    r_next.osc_en   = r_next.ctrl[OSC_EN_BIT];
    r_next.gate_clr = ~r_next.ctrl[RUN_BIT];
  end

  always_ff @(posedge core_clk) begin
    r_reg <= r_next;
  end

  // Outputs straight from flops
  assign prdata             = r_reg.rdata;
  assign pready             = r_reg.ready;
  assign pslverr            = r_reg.slverr;
  assign irq                = r_reg.irq;
  assign crystal_osc_enable = r_reg.osc_en;
  assign gate_ff_clear      = r_reg.gate_clr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Helper: no count writes and no other reset this cycle
  logic no_cnt_wr;
  assign no_cnt_wr = ~wr_lo & ~wr_hi & ~other_rst;

  ovf_flag_a: assert property (wrap |=> r_reg.stat[EV_OVF])
    else $error("overflow flag not set at wrap");

  cnt_step_a: assert property ((inc && no_cnt_wr)
    |=> r_reg.cnt == 16'($past(r_reg.cnt) + 16'h0001))
    else $error("count did not advance by one");

  stop_hold_a: assert property ((!run && no_cnt_wr)
    |=> $stable(r_reg.cnt))
    else $error("count moved while stopped");

  gate_clr_a: assert property ((!run && !wr_ctrl)
    |=> gate_ff_clear)
    else $error("gate clear missing while stopped");

  stop_flag_a: assert property ((stop_ev && !other_rst)
    |=> r_reg.stat[EV_STOP])
    else $error("stop flag not set when run cleared");

  sys_rate_a: assert property ((run && cs == SRC_SYS
    && tk.pre_sel == 2'h0 && !tk.pre_clr) |-> inc)
    else $error("system clock source missed a cycle");

  insn_rate_a: assert property ((cs == SRC_INSN && tk.cnt_tick
    && !wr_ctrl && !other_rst)
    |=> (cs != SRC_INSN || !tk.cnt_tick) [*3])
    else $error("instruction clock faster than one in four");

  cap_src_a: assert property (cs == SRC_CAP
    |-> tk.cnt_tick == tk.src_edge[XS_CAP])
    else $error("capacitive source not routed to count");

  pin_src_a: assert property ((cs == SRC_PIN && !osc)
    |-> tk.cnt_tick == tk.src_edge[XS_PIN])
    else $error("pin source not routed to count");

  xtal_src_a: assert property ((cs == SRC_PIN && osc)
    |-> tk.cnt_tick == tk.src_edge[XS_XTAL])
    else $error("crystal source not routed to count");

  sync_path_a: assert property ((cs[1] && !r_reg.ctrl[SYNC_DIS_BIT])
    |-> !tk.bypass)
    else $error("external source bypassed with sync enabled");

  sync_ignore_a: assert property (!cs[1] |-> !tk.bypass)
    else $error("internal source took the bypass path");

  cnt_wr_lo_a: assert property (wr_lo
    |=> r_reg.cnt[7:0] == $past(pwdata[7:0]))
    else $error("count low byte write lost");

  cnt_wr_hi_a: assert property (wr_hi
    |=> r_reg.cnt[15:8] == $past(pwdata[7:0]))
    else $error("count high byte write lost");

  // Bus answer follows every setup made outside the other reset
  ready_answer_a: assert property (setup |=> pready)
    else $error("no ready after setup cycle");

  // Bus answer stands one cycle
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  // Error only with an answer
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");

  // Read data zero outside answer
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero while idle");

  irq_mask_a: assert property ((r_reg.mask == 2'h0 && !wr_mask)
    |=> !irq)
    else $error("interrupt raised with all events masked");

  irq_pie_a: assert property ((!r_reg.pie && !wr_cfg) |=> !irq)
    else $error("interrupt raised without peripheral enable");

  ctrl_bit1_a: assert property (r_reg.ctrl[1] == 1'b0)
    else $error("control bit one not zero");

  osc_follow_a: assert property (wr_ctrl
    |=> crystal_osc_enable == $past(pwdata[OSC_EN_BIT]))
    else $error("crystal enable did not follow control");

  ctrl_keep_a: assert property ((other_rst && !wr_ctrl)
    |=> $stable(r_reg.ctrl))
    else $error("control changed by other reset");

  // Main scenarios
  wrap_c:  cover property (wrap);
  irq_c:   cover property (!irq ##1 irq);
  pin_c:   cover property (cs == SRC_PIN && !osc && inc);
  xtal_c:  cover property (cs == SRC_PIN && osc && inc);
  stop_c:  cover property (stop_ev);
endmodule // tmo_timer_core

// file: verif/tb_top.sv
// Self-checking bench for the timer one clock and control block
`timescale 1ns/100ps
module tb_top
  import tmo_pkg::*;
;
  logic        core_clk  = 1'h0;
  logic        sys_rst   = 1'h1;
  logic        other_rst = 1'h0;
  logic        psel      = 1'h0;
  logic        penable   = 1'h0;
  logic        pwrite    = 1'h0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xtal_en;
  logic        gate_clr;
  logic        irq;
  logic [2:0]  lanes     = 3'h0;
  logic [1:0]  sel_lane  = 2'h3;
  logic        lane_lvl  = 1'h0;
  logic [7:0]  rnd       = 8'h54;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc       = 0;

  // Free-running 100 MHz clock
  initial forever #5 core_clk = ~core_clk;

  tmo_timer_core i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .other_rst(other_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_sense_oscillator(lanes[0]),
    .ext_count_input(lanes[1]), .crystal_osc_pins(lanes[2]),
    .crystal_osc_enable(xtal_en), .gate_ff_clear(gate_clr), .irq(irq)
  );

  // Next pseudo-random value
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Compare one bus answer
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Compare one pin level
  task automatic cmp_pin(input logic got, input logic want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Counts, verdict and end of run
  task automatic close_out();
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One APB transfer, noting the expected answer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic ee);
    exp_q.push_back({~w, ee, w ? 32'h0 : d});
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1) @(posedge core_clk);
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h1, a, {rnd, rnd, rnd, d}, 1'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h0, a, {24'h0, d}, 1'h0);
  endtask

  // Take the oldest note whenever an answer shows
  always @(posedge core_clk) begin
    if (pready === 1'h1) begin
      e = exp_q.pop_front();
      cmp_bus({e[33], pslverr, e[33] ? prdata : 32'h0}, e);
    end
  end

  // Selected source lane follows the bench, others get noise
  always @(posedge core_clk) begin
    rnd <= lfsr(rnd);
    for (int i = 0; i < 3; i++)
      lanes[i] <= (sel_lane == i) ? lane_lvl : rnd[i];
  end

  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    logic [7:0] v;
    int         n;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    cmp_pin(gate_clr, 1'h1);
    cmp_pin(xtal_en, 1'h0);
    // reset values and an unmapped place
    for (int a = 0; a <= 24; a += 4)
      xfer(1'h0, a[7:0], 32'h0, a == 24);
    xfer(1'h1, 8'h18, 32'hffffffff, 1'h1);
    // control kept by the other reset, cleared by power reset
    v = rnd & 8'hfe;
    wr(OFF_CTRL, v);
    cmp_pin(xtal_en, v[3]);
    wr(OFF_CNT_LO, 8'h5a);
    wr(OFF_CNT_HI, 8'ha5);
    other_rst <= 1'h1;
    @(posedge core_clk);
    other_rst <= 1'h0;
    @(posedge core_clk);
    rd(OFF_CTRL, v & CTRL_IMPL);
    rd(OFF_CNT_LO, 8'h5a);
    rd(OFF_CNT_HI, 8'ha5);
    sys_rst <= 1'h1;
    @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    rd(OFF_CTRL, CTRL_RST);
    for (int c = 0; c < 12; c++) begin
      n = c / 4;
      v = {(n == 0) ? SRC_CAP : SRC_PIN, c[1:0], n == 2, rnd[2], 2'h0};
      sel_lane <= n[1:0];
      lane_lvl <= 1'h0;
      wr(OFF_CTRL, v);
      wr(OFF_CNT_LO, 8'h00);
      wr(OFF_CNT_HI, 8'h00);
      wr(OFF_CTRL, v | 8'h01);
      cmp_pin(gate_clr, 1'h0);
      cmp_pin(xtal_en, v[3]);
      repeat (16) begin
        lane_lvl <= 1'h1;
        repeat (4) @(posedge core_clk);
        lane_lvl <= 1'h0;
        repeat (4) @(posedge core_clk);
      end
      repeat (8) @(posedge core_clk);
      wr(OFF_CTRL, v);
      rd(OFF_CNT_LO, 8'h10 >> c[1:0]);
      rd(OFF_CNT_HI, 8'h00);
    end
    sel_lane <= 2'h3;
    // internal sources, overflow time and interrupt
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_IRQ_CFG, 8'h01);
    for (int s = 0; s < 2; s++) begin
      v = {s[0] ? SRC_INSN : SRC_SYS, 2'h0, 1'h0, rnd[3], 2'h1};
      wr(OFF_CTRL, 8'h00);
      wr(OFF_CNT_LO, 8'hf0);
      wr(OFF_CNT_HI, 8'hff);
      wr(OFF_IRQ_STAT, 8'h03);
      cmp_pin(irq, 1'h0);
      wr(OFF_CTRL, v);
      n = 0;
      while (irq !== 1'h1 && n < 200) begin
        @(posedge core_clk);
        n++;
      end
      cmp_pin(s ? (n >= 58 && n <= 72) : (n >= 13 && n <= 20), 1'h1);
      wr(OFF_CTRL, 8'h00);
    end
    cmp_pin(irq, 1'h1);
    wr(OFF_IRQ_CFG, 8'h00);
    cmp_pin(irq, 1'h0);
    wr(OFF_IRQ_CFG, 8'h01);
    cmp_pin(irq, 1'h1);
    wr(OFF_IRQ_MASK, 8'h00);
    cmp_pin(irq, 1'h0);
    rd(OFF_IRQ_STAT, 8'h03);
    wr(OFF_IRQ_STAT, 8'h03);
    wr(OFF_IRQ_MASK, 8'h01);
    cmp_pin(irq, 1'h0);
    rd(OFF_IRQ_STAT, 8'h00);
    close_out();
  end
endmodule // tb_top
